// *** core/flash_host.sv ***
// Serial flash host: runs one command per request on the flash pins
//
// How it works
// RULE_01: Plain read 3 addr; fast read adds 8 dummy
// RULE_02: Dual output read: x1 addr, 8 dummy, x2 data
// RULE_03: Dual IO read: x2 addr, 4 or 8 dummy
// RULE_04: Quad output read: x1 addr, 8 dummy, x4 data
// RULE_05: Quad IO read: x4 addr, 6 or 10 dummy
// RULE_06: Word quad read: 4 dummy, even address
// RULE_07: 4K wipe: opcode plus three address bytes
// RULE_08: 32K wipe: opcode plus three address bytes
// RULE_09: 64K wipe with address; chip wipe without
// RULE_10: Page write x1 data; quad page write x4
// RULE_11: Latch set and clear carry opcode only
// RULE_12: Volatile status unlock carries opcode only
// RULE_13: OTP read: 3 address bytes, 8 dummy
// RULE_14: Status reads return exactly one byte
// RULE_15: Status pair write sends one or two bytes
// RULE_16: High status write sends exactly one byte
// RULE_17: JEDEC id read returns at most three bytes
// RULE_18: Maker id read: three address bytes, x1
// RULE_19: Maker id x2: 4 dummy; x4: 6 dummy
// RULE_20: Deep sleep entry is opcode only
// RULE_21: Wake command has address, returns one byte
// RULE_22: Enhanced release is a plain opcode
// RULE_23: Reset only straight after reset arm
// RULE_24: Chip select rises on byte boundary; maker id x2 and x4 reads end 4 and 6 bits past one
// RULE_25: Unknown opcodes are never sent
// RULE_26: Four wire command mode is never entered
// RULE_27: Address goes MSB byte and bit first
`timescale 1ns/1ps
`include "sfh_cfg.svh"
module flash_host #(
  parameter int RECOVER_CYC = `RST_RECOVER_CYC
) (
  input  wire logic           clk,
  input  wire logic           sys_rst,
  input  wire logic           cmd_valid,
  output logic                cmd_ready,
  input  wire sfh_pkg::opcode_t cmd_op,
  input  wire logic [23:0]    cmd_addr,
  input  wire logic           cmd_alt,
  input  wire logic [8:0]     cmd_len,
  input  wire logic           wbuf_we,
  input  wire logic [7:0]     wbuf_addr,
  input  wire logic [7:0]     wbuf_data,
  output logic                rd_valid,
  output logic [7:0]          rd_data,
  output logic                done,
  output logic                cmd_err,
  output logic                asleep,
  output logic                flash_sclk,
  output logic                flash_cs_n,
  input  wire logic [3:0]     flash_io_i,
  output logic [3:0]          flash_io_o,
  output logic [3:0]          flash_io_oe
);
  import sfh_pkg::*;

  host_st_t   st;
  host_st_t   n;
  cmd_info_t  info;
  logic       accept;
  logic       bad;
  logic       tick;
  logic       last;
  logic       go_addr;
  logic       go_dummy;
  logic [7:0] rb;
  logic [8:0] len;
  page_buf_if bi ();

  // =========================================================
  // Helpers
  function automatic cmd_info_t mk(logic a, logic [2:0] al, logic [3:0] m, logic [3:0] d,
                                   logic r, logic w, logic [2:0] dl, logic f, logic [1:0] c);
    mk = '{known: 1'b1, addr: a, alanes: al, mode: m, dummy: d, rd: r, wr: w,
           dlanes: dl, fixed: f, cap: c};
  endfunction : mk

  function automatic cmd_info_t decode(opcode_t op, logic alt);
    cmd_info_t c;
    c = mk(1'b0, 3'd1, 4'd0, 4'd0, 1'b0, 1'b0, 3'd1, 1'b0, 2'd0);
    case (op)
      `OP_ARRAY_READ:      c = mk(1'b1, 3'd1, 4'd0, 4'd0, 1'b1, 1'b0, 3'd1, 1'b0, 2'd0); // [RULE_01]
      `OP_FAST_READ:       c = mk(1'b1, 3'd1, 4'd0, `DUMMY_X1, 1'b1, 1'b0, 3'd1, 1'b0, 2'd0); // [RULE_01]
      `OP_DUAL_OUT_READ:   c = mk(1'b1, 3'd1, 4'd0, `DUMMY_X1, 1'b1, 1'b0, 3'd2, 1'b0, 2'd0); // [RULE_02]
      `OP_DUAL_IO_READ:    c = mk(1'b1, 3'd2, `MODE_IO2, alt ? `DUMMY_IO2_ALT : `DUMMY_IO2,
                                  1'b1, 1'b0, 3'd2, 1'b0, 2'd0); // [RULE_03]
      `OP_QUAD_OUT_READ:   c = mk(1'b1, 3'd1, 4'd0, `DUMMY_X1, 1'b1, 1'b0, 3'd4, 1'b0, 2'd0); // [RULE_04]
      `OP_QUAD_IO_READ:    c = mk(1'b1, 3'd4, `MODE_IO4, alt ? `DUMMY_IO4_ALT : `DUMMY_IO4,
                                  1'b1, 1'b0, 3'd4, 1'b0, 2'd0); // [RULE_05]
      `OP_QUAD_WORD_READ:  c = mk(1'b1, 3'd4, `MODE_IO4, `DUMMY_WORD, 1'b1, 1'b0, 3'd4, 1'b0, 2'd0); // [RULE_06]
      `OP_WIPE_4K:         c = mk(1'b1, 3'd1, 4'd0, 4'd0, 1'b0, 1'b0, 3'd1, 1'b0, 2'd0); // [RULE_07]
      `OP_WIPE_32K:        c = mk(1'b1, 3'd1, 4'd0, 4'd0, 1'b0, 1'b0, 3'd1, 1'b0, 2'd0); // [RULE_08]
      `OP_WIPE_64K:        c = mk(1'b1, 3'd1, 4'd0, 4'd0, 1'b0, 1'b0, 3'd1, 1'b0, 2'd0); // [RULE_09]
      `OP_PAGE_WRITE:      c = mk(1'b1, 3'd1, 4'd0, 4'd0, 1'b0, 1'b1, 3'd1, 1'b0, 2'd0); // [RULE_10]
      `OP_QUAD_PAGE_WRITE: c = mk(1'b1, 3'd1, 4'd0, 4'd0, 1'b0, 1'b1, 3'd4, 1'b0, 2'd0); // [RULE_10]
      `OP_OTP_READ:        c = mk(1'b1, 3'd1, 4'd0, `DUMMY_X1, 1'b1, 1'b0, 3'd1, 1'b0, 2'd0); // [RULE_13]
      `OP_STATUS_LOW_RD,
      `OP_STATUS_HIGH_RD:  c = mk(1'b0, 3'd1, 4'd0, 4'd0, 1'b1, 1'b0, 3'd1, 1'b1, 2'd1); // [RULE_14]
      `OP_STATUS_PAIR_WR:  c = mk(1'b0, 3'd1, 4'd0, 4'd0, 1'b0, 1'b1, 3'd1, 1'b0,
                                  `STATUS_PAIR_MAX); // [RULE_15]
      `OP_STATUS_HIGH_WR:  c = mk(1'b0, 3'd1, 4'd0, 4'd0, 1'b0, 1'b1, 3'd1, 1'b1, 2'd1); // [RULE_16]
      `OP_JEDEC_ID:        c = mk(1'b0, 3'd1, 4'd0, 4'd0, 1'b1, 1'b0, 3'd1, 1'b0,
                                  `JEDEC_ID_MAX); // [RULE_17]
      `OP_MAKER_ID:        c = mk(1'b1, 3'd1, 4'd0, 4'd0, 1'b1, 1'b0, 3'd1, 1'b0, 2'd0); // [RULE_18]
      `OP_MAKER_ID_X2:     c = mk(1'b1, 3'd1, 4'd0, `DUMMY_ID2, 1'b1, 1'b0, 3'd2, 1'b0, 2'd0); // [RULE_19]
      `OP_MAKER_ID_X4:     c = mk(1'b1, 3'd1, 4'd0, `DUMMY_ID4, 1'b1, 1'b0, 3'd4, 1'b0, 2'd0); // [RULE_19]
      `OP_WAKE:            c = mk(1'b1, 3'd1, 4'd0, 4'd0, 1'b1, 1'b0, 3'd1, 1'b1, 2'd1); // [RULE_21]
      `OP_WIPE_ALL_A, `OP_WIPE_ALL_B,                                         // [RULE_09]
      `OP_LATCH_SET, `OP_LATCH_CLEAR, `OP_VOL_UNLOCK,                         // [RULE_11] [RULE_12]
      `OP_DEEP_SLEEP, `OP_ENH_RELEASE,                                        // [RULE_20] [RULE_22]
      `OP_RESET_ARM, `OP_RESET:
                           c = mk(1'b0, 3'd1, 4'd0, 4'd0, 1'b0, 1'b0, 3'd1, 1'b0, 2'd0);
      default:             c.known = 1'b0; // [RULE_25]
    endcase
    return c;
  endfunction : decode

  function automatic logic [4:0] cyc(logic [5:0] bits, logic [2:0] l);
    case (l)
      3'd4:    return {1'b0, bits[5:2]};
      3'd2:    return bits[5:1];
      default: return bits[4:0];
    endcase
  endfunction : cyc

  function automatic logic [31:0] shl(logic [31:0] s, logic [2:0] l);
    case (l)
      3'd4:    return {s[27:0], 4'h0};
      3'd2:    return {s[29:0], 2'h0};
      default: return {s[30:0], 1'h0};
    endcase
  endfunction : shl

  function automatic logic [7:0] merge(logic [7:0] b, logic [3:0] in, logic [2:0] l);
    case (l)
      3'd4:    return {b[3:0], in};
      3'd2:    return {b[5:0], in[1:0]};
      default: return {b[6:0], in[1]};
    endcase
  endfunction : merge

  // Pin drive as {oe, out}; io2/io3 held high unless the command has a quad address or data phase
  function automatic logic [7:0] pins(logic [31:0] s, logic [2:0] l, logic en, logic q4);
    logic [3:0] m;
    logic [3:0] o;
    m = 4'h1;
    o = 4'h0;
    if (en)
    begin
      m = (l == 3'd4) ? 4'hf : ((l == 3'd2) ? 4'h3 : 4'h1);
      o = (l == 3'd4) ? s[31:28] : ((l == 3'd2) ? {2'h0, s[31:30]} : {3'h0, s[31]});
    end
    else if (l != 3'd1)
    begin
      m = 4'h0;
    end
    if (!q4)
    begin
      m[3:2] = 2'h3;
      o[3:2] = 2'h3;
    end
    return {m, o};
  endfunction : pins

  // =========================================================
  // Page buffer
  assign bi.we    = wbuf_we;
  assign bi.waddr = wbuf_addr;
  assign bi.wdata = wbuf_data;
  assign bi.raddr = st.bidx;

  page_buf u_buf (
    .clk (clk),
    .bus (bi)
  );

  // =========================================================
  // Next state
  always_comb
  begin
    n        = st;
    n.rd_valid = 1'b0;
    n.done     = 1'b0;
    n.cmd_err  = 1'b0;
    // Pin synchroniser: a bit counts once stages two and three agree
    n.s1  = flash_io_i;
    n.s2  = st.s1;
    n.s3  = st.s2;
    n.inq = (~(st.s2 ^ st.s3) & st.s3) | ((st.s2 ^ st.s3) & st.inq);
    if (st.recov != 13'h0)
    begin
      n.recov = st.recov - 13'h1;
    end
    tick     = (st.div == `SCLK_HALF_LAST);
    n.div    = tick ? 3'h0 : st.div + 3'h1;
    info     = decode(cmd_op, cmd_alt);
    accept   = cmd_valid && st.cmd_ready;
    bad      = !info.known || (cmd_op == `OP_FOUR_WIRE)              // [RULE_25] [RULE_26]
               || (cmd_op == `OP_RESET && !st.armed)                 // [RULE_23]
               || (st.asleep && cmd_op != `OP_WAKE);                 // [RULE_20]
    len      = (cmd_len == 9'h0) ? 9'h1 : cmd_len;
    last     = (st.clks == 5'h1);
    rb       = merge(st.rbyte, st.inq, st.lanes);
    go_addr  = (st.state == S_CMD) && st.info.addr;
    go_dummy = !go_addr && (st.state inside {S_CMD, S_ADDR}) && (st.info.dummy != 4'h0);
    unique case (st.state)
      S_IDLE:
      begin
        n.div       = 3'h0;
        n.cmd_ready = (st.recov == 13'h0);
        if (accept && bad)
        begin
          n.cmd_err = 1'b1;
        end
        else if (accept)
        begin
          n.cmd_ready = 1'b0;
          n.info      = info;
          n.op        = cmd_op;
          n.addr      = (cmd_op == `OP_QUAD_WORD_READ) ? {cmd_addr[23:1], 1'b0} : cmd_addr; // [RULE_06]
          if (info.fixed)
          begin
            n.nbytes = {7'h0, info.cap};                                  // [RULE_14] [RULE_16]
          end
          else if (info.cap != 2'h0 && len > {7'h0, info.cap})
          begin
            n.nbytes = {7'h0, info.cap};                                  // [RULE_15] [RULE_17]
          end
          else
          begin
            n.nbytes = len;
          end
          n.bidx   = 8'h0;
          n.armed  = (cmd_op == `OP_RESET_ARM);                           // [RULE_23]
          n.asleep = (cmd_op == `OP_DEEP_SLEEP);                          // [RULE_20] [RULE_21]
          if (cmd_op == `OP_RESET)
          begin
            n.recov = 13'(RECOVER_CYC);
          end
          n.cs_n  = 1'b0;
          n.state = S_CMD;
          n.lanes = 3'd1;
          n.clks  = cyc(`OPCODE_BITS, 3'd1);
          n.sh    = {cmd_op, 24'h0};
          {n.io_oe, n.io_o} = pins({cmd_op, 24'h0}, 3'd1, 1'b1,
                                   info.alanes == 3'd4 || info.dlanes == 3'd4);
        end
      end
      S_CMD, S_ADDR, S_DUMMY, S_WDATA, S_RDATA:
      begin
        if (tick && !st.sclk)
        begin
          n.sclk = 1'b1;
        end
        else if (tick)
        begin
          // Falling edge: sample, then shift or change phase
          n.sclk = 1'b0;
          n.clks = st.clks - 5'h1;
          if (st.state == S_RDATA)
          begin
            n.rbyte = rb;
          end
          if (st.modeleft != 4'h0)
          begin
            n.modeleft = st.modeleft - 4'h1;
          end
          if (!last)
          begin
            n.sh = shl(st.sh, st.lanes);
            {n.io_oe, n.io_o} = pins(n.sh, st.lanes, st.state inside {S_CMD, S_ADDR, S_WDATA}
                                     || n.modeleft != 4'h0,
                                     st.info.alanes == 3'd4 || st.info.dlanes == 3'd4);
          end
          else
          begin
            if (st.state == S_RDATA)
            begin
              n.rd_valid = 1'b1;
              n.rd_data  = rb;
            end
            if (st.state inside {S_WDATA, S_RDATA})
            begin
              n.nbytes = st.nbytes - 9'h1;
            end
            if (go_addr)
            begin
              n.state = S_ADDR;
              n.lanes = st.info.alanes;
              n.sh    = {st.addr, 8'h0};                                  // [RULE_27]
              n.clks  = cyc(`ADDR_BITS, st.info.alanes);
            end
            else if (go_dummy)
            begin
              n.state    = S_DUMMY;
              n.lanes    = st.info.alanes;
              n.sh       = 32'h0;
              n.clks     = {1'b0, st.info.dummy};
              n.modeleft = st.info.mode;
            end
            else if ((st.state inside {S_WDATA, S_RDATA}) ? st.nbytes != 9'h1
                     : (st.info.wr || st.info.rd))
            begin
              n.state = st.info.wr ? S_WDATA : S_RDATA;
              n.lanes = st.info.dlanes;
              n.sh    = {bi.rdata, 24'h0};
              n.clks  = cyc(`OPCODE_BITS, st.info.dlanes);
              if (st.info.wr)
              begin
                n.bidx = st.bidx + 8'h1;
              end
            end
            else
            begin
              n.state = S_END;                                            // [RULE_24]
              n.lanes = 3'd1;
            end
            {n.io_oe, n.io_o} = pins(n.sh, n.lanes, n.state inside {S_ADDR, S_WDATA}
                                     || n.modeleft != 4'h0,
                                     st.info.alanes == 3'd4 || st.info.dlanes == 3'd4);
          end
        end
      end
      S_END:
      begin
        if (tick)
        begin
          n.cs_n = 1'b1;                                                  // [RULE_24]
          n.state = S_GAP;
          n.clks  = `CS_GAP_CYC;
          {n.io_oe, n.io_o} = pins(32'h0, 3'd1, 1'b0, 1'b0);
        end
      end
      S_GAP:
      begin
        n.clks = st.clks - 5'h1;
        if (last)
        begin
          n.state = S_IDLE;
          n.done  = 1'b1;
        end
      end
    endcase
  end

  // =========================================================
  // State register
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st       <= '0;
      st.state <= S_IDLE;
      st.cs_n  <= 1'b1;
      st.lanes <= 3'd1;
      st.io_oe <= 4'hd;
      st.io_o  <= 4'hc;
    end
    else
    begin
      st <= n;
    end
  end

  assign cmd_ready   = st.cmd_ready;
  assign rd_valid    = st.rd_valid;
  assign rd_data     = st.rd_data;
  assign done        = st.done;
  assign cmd_err     = st.cmd_err;
  assign asleep      = st.asleep;
  assign flash_sclk  = st.sclk;
  assign flash_cs_n  = st.cs_n;
  assign flash_io_o  = st.io_o;
  assign flash_io_oe = st.io_oe;

  // =========================================================
  // Checks
  logic [2:0] edges_q;
  logic [3:0] dcnt_q;

  // Bits moved per frame and clock edges per dummy phase
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      edges_q <= 3'h0;
      dcnt_q  <= 4'h0;
    end
    else
    begin
      // Bits moved modulo eight, one per lane on each rising clock
      edges_q <= st.cs_n ? 3'h0 : edges_q + ((n.sclk && !st.sclk) ? st.lanes : 3'h0);
      dcnt_q  <= (st.state == S_CMD) ? 4'h0 : dcnt_q + 4'(st.state == S_DUMMY && n.sclk && !st.sclk);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_byte_bound;
    $rose(st.cs_n) && !st.info.rd |-> edges_q == 3'h0;
  endproperty
  a_byte_bound: assert property (p_byte_bound) else $error("cs rose off a byte boundary"); // [RULE_24]

  property p_cs_gap;
    $rose(st.cs_n) |-> st.cs_n [*5];
  endproperty
  a_cs_gap: assert property (p_cs_gap) else $error("deselect time too short"); // [RULE_24]

  property p_unknown;
    accept && !info.known |=> st.cmd_err && st.cs_n;
  endproperty
  a_unknown: assert property (p_unknown) else $error("unknown opcode was sent"); // [RULE_25]

  property p_reset_seq;
    accept && cmd_op == `OP_RESET && !st.armed |=> st.cmd_err && st.state == S_IDLE;
  endproperty
  a_reset_seq: assert property (p_reset_seq) else $error("reset sent without arm"); // [RULE_23]

  property p_sleep;
    accept && st.asleep && cmd_op != `OP_WAKE |=> st.cs_n [*2];
  endproperty
  a_sleep: assert property (p_sleep) else $error("command sent while asleep"); // [RULE_20]

  property p_four_wire;
    accept && cmd_op == `OP_FOUR_WIRE |=> st.cmd_err ##1 st.cs_n;
  endproperty
  a_four_wire: assert property (p_four_wire) else $error("four wire mode entered"); // [RULE_26]

  property p_addr_msb;
    st.state == S_ADDR && $past(st.state) != S_ADDR && st.lanes == 3'd1
      |-> st.io_o[0] == st.addr[23];
  endproperty
  a_addr_msb: assert property (p_addr_msb) else $error("address not MSB first"); // [RULE_27]

  property p_dummy;
    $past(st.state) == S_DUMMY && st.state != S_DUMMY |-> dcnt_q == st.info.dummy;
  endproperty
  a_dummy: assert property (p_dummy) else $error("dummy clock count wrong"); // [RULE_01] [RULE_05]

  property p_word_even;
    st.state == S_ADDR && st.op == `OP_QUAD_WORD_READ |-> !st.addr[0];
  endproperty
  a_word_even: assert property (p_word_even) else $error("word read address odd"); // [RULE_06]

  property p_fixed_len;
    accept && !bad && (cmd_op == `OP_STATUS_LOW_RD || cmd_op == `OP_STATUS_HIGH_WR)
      |=> st.nbytes == 9'h1;
  endproperty
  a_fixed_len: assert property (p_fixed_len) else $error("fixed length wrong"); // [RULE_14]

  property p_jedec_cap;
    accept && !bad && cmd_op == `OP_JEDEC_ID |=> st.nbytes <= 9'h3 && st.nbytes != 9'h0;
  endproperty
  a_jedec_cap: assert property (p_jedec_cap) else $error("id read too long"); // [RULE_17]

endmodule : flash_host

// *** core/sfh_cfg.svh ***
// Constants of the serial flash host: opcodes, phase lengths and timing
`ifndef SFH_CFG_SVH
`define SFH_CFG_SVH

// =========================================================
// Timing
`define CLK_PERIOD_NS      5
`define SCLK_HALF_LAST     3'd3
`define CS_GAP_CYC         5'd4
`define RST_RECOVER_NS     30000
`define RST_RECOVER_CYC    ((`RST_RECOVER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// =========================================================
// Phase lengths
`define OPCODE_BITS        6'd8
`define ADDR_BITS          6'd24
`define DUMMY_X1           4'd8
`define DUMMY_IO2          4'd4
`define DUMMY_IO2_ALT      4'd8
`define DUMMY_IO4          4'd6
`define DUMMY_IO4_ALT      4'd10
`define DUMMY_WORD         4'd4
`define DUMMY_ID2          4'd4
`define DUMMY_ID4          4'd6
`define MODE_IO2           4'd4
`define MODE_IO4           4'd2
`define JEDEC_ID_MAX       2'd3
`define STATUS_PAIR_MAX    2'd2

// =========================================================
// Opcodes
`define OP_ARRAY_READ      8'h03
`define OP_FAST_READ       8'h0b
`define OP_DUAL_OUT_READ   8'h3b
`define OP_DUAL_IO_READ    8'hbb
`define OP_QUAD_OUT_READ   8'h6b
`define OP_QUAD_IO_READ    8'heb
`define OP_QUAD_WORD_READ  8'he7
`define OP_WIPE_4K         8'h20
`define OP_WIPE_32K        8'h52
`define OP_WIPE_64K        8'hd8
`define OP_WIPE_ALL_A      8'h60
`define OP_WIPE_ALL_B      8'hc7
`define OP_PAGE_WRITE      8'h02
`define OP_QUAD_PAGE_WRITE 8'h32
`define OP_LATCH_SET       8'h06
`define OP_LATCH_CLEAR     8'h04
`define OP_VOL_UNLOCK      8'h50
`define OP_OTP_READ        8'h48
`define OP_STATUS_LOW_RD   8'h05
`define OP_STATUS_HIGH_RD  8'h35
`define OP_STATUS_PAIR_WR  8'h01
`define OP_STATUS_HIGH_WR  8'h31
`define OP_JEDEC_ID        8'h9f
`define OP_MAKER_ID        8'h90
`define OP_MAKER_ID_X2     8'h92
`define OP_MAKER_ID_X4     8'h94
`define OP_DEEP_SLEEP      8'hb9
`define OP_WAKE            8'hab
`define OP_ENH_RELEASE     8'hff
`define OP_RESET_ARM       8'h66
`define OP_RESET           8'h99
`define OP_FOUR_WIRE       8'h38

`endif

// *** core/sfh_pkg.sv ***
// Types shared by the serial flash host modules
package sfh_pkg;

  typedef logic [7:0] opcode_t;

  // =========================================================
  // Transaction sequencer states
  typedef enum logic [7:0] {
    S_IDLE  = 8'b0000_0001,
    S_CMD   = 8'b0000_0010,
    S_ADDR  = 8'b0000_0100,
    S_DUMMY = 8'b0000_1000,
    S_WDATA = 8'b0001_0000,
    S_RDATA = 8'b0010_0000,
    S_END   = 8'b0100_0000,
    S_GAP   = 8'b1000_0000
  } state_t;

  // =========================================================
  // Shape of one command
  typedef struct packed {
    logic       known;
    logic       addr;
    logic [2:0] alanes;
    logic [3:0] mode;
    logic [3:0] dummy;
    logic       rd;
    logic       wr;
    logic [2:0] dlanes;
    logic       fixed;
    logic [1:0] cap;
  } cmd_info_t;

  // =========================================================
  // Whole state of the host
  typedef struct packed {
    state_t     state;
    logic       cs_n;
    logic       sclk;
    logic [3:0] io_o;
    logic [3:0] io_oe;
    logic [2:0] div;
    logic [4:0] clks;
    logic [2:0] lanes;
    logic [31:0] sh;
    cmd_info_t  info;
    opcode_t    op;
    logic [23:0] addr;
    logic [8:0] nbytes;
    logic [7:0] bidx;
    logic [7:0] rbyte;
    logic [3:0] modeleft;
    logic       armed;
    logic       asleep;
    logic [12:0] recov;
    logic [3:0] s1;
    logic [3:0] s2;
    logic [3:0] s3;
    logic [3:0] inq;
    logic       cmd_ready;
    logic       rd_valid;
    logic [7:0] rd_data;
    logic       done;
    logic       cmd_err;
  } host_st_t;

endpackage : sfh_pkg

// *** core/page_buf_if.sv ***
// Interface between the host sequencer and its page buffer
`timescale 1ns/1ps
interface page_buf_if;
  logic       we;
  logic [7:0] waddr;
  logic [7:0] wdata;
  logic [7:0] raddr;
  logic [7:0] rdata;

  modport owner (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem   (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : page_buf_if

// *** core/page_buf.sv ***
// Page buffer holding program data, registered read port
`timescale 1ns/1ps
module page_buf (
  input wire logic clk,
  page_buf_if.mem  bus
);

  logic [7:0] mem [0:255];

  // =========================================================
  // Write port and registered read
  always_ff @(posedge clk)
  begin
    if (bus.we)
    begin
      mem[bus.waddr] <= bus.wdata;
    end
    bus.rdata <= mem[bus.raddr];
  end

endmodule : page_buf

// *** verif/flash_dev.sv ***
// Behavioural serial flash device on the host pins
`timescale 1ns/1ps
module flash_dev (
  input  wire logic       sclk,
  input  wire logic       cs_n,
  input  wire logic [3:0] io_o,
  input  wire logic [3:0] io_oe,
  input  wire logic [7:0] pat,
  output logic [3:0]      io_i,
  output logic [7:0]      op_q,
  output logic [23:0]     ad_q,
  output logic [31:0]     sr_q,
  output int              n_q
);
  logic [3:0] dev_o = 4'h0;
  // ==========================================
  // Pin level from both drivers
  assign io_i = (io_oe & io_o) | (~io_oe & dev_o);
  // Select falling (clock low) starts a frame; opcode then address, MSB first
  always @(posedge sclk or negedge cs_n)
    if (!sclk) n_q = 0;
    else
    begin
      sr_q = {sr_q[30:0], io_i[0]};
      n_q = n_q + 1;
      if (n_q == 8) op_q = sr_q[7:0];
      if (n_q == 32) ad_q = sr_q[23:0];
    end
  // Data out on falling edge, flipped once released
  always @(negedge sclk or posedge cs_n)
    if (cs_n) dev_o <= ~dev_o;
    else dev_o <= {4{pat[3'd7 - n_q[2:0]]}};
endmodule : flash_dev

// *** verif/flash_host_test.sv ***
// Self-checking bench for the serial flash host
`timescale 1ns/1ps
module flash_host_test;
  import sfh_pkg::*;
  logic        clk, sys_rst, cmd_valid, cmd_alt, wbuf_we;
  logic        cmd_ready, rd_valid, done, cmd_err, asleep, sclk, cs_n;
  opcode_t     cmd_op;
  logic [23:0] cmd_addr, ad_q;
  logic [8:0]  cmd_len;
  logic [7:0]  wbuf_addr, wbuf_data, rd_data, pat, op_q;
  logic [3:0]  io_i, io_o, io_oe;
  logic [31:0] sr_q;
  logic [7:0]  wb [4];
  int          n_q, err_total = 0, comparisons = 0;
  opcode_t     ops [27] = '{8'h03, 8'h0b, 8'h3b, 8'hbb, 8'h6b, 8'heb, 8'he7, 8'h20, 8'h52,
    8'hd8, 8'h60, 8'hc7, 8'h02, 8'h32, 8'h06, 8'h04, 8'h50, 8'h48, 8'h05, 8'h35, 8'h01,
    8'h31, 8'h9f, 8'h90, 8'h92, 8'h94, 8'hff};
  flash_host #(.RECOVER_CYC(20)) flash_host_i (.clk(clk), .sys_rst(sys_rst),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
    .cmd_alt(cmd_alt), .cmd_len(cmd_len), .wbuf_we(wbuf_we), .wbuf_addr(wbuf_addr),
    .wbuf_data(wbuf_data), .rd_valid(rd_valid), .rd_data(rd_data), .done(done),
    .cmd_err(cmd_err), .asleep(asleep), .flash_sclk(sclk), .flash_cs_n(cs_n),
    .flash_io_i(io_i), .flash_io_o(io_o), .flash_io_oe(io_oe));
  flash_dev flash_dev_i (.sclk(sclk), .cs_n(cs_n), .io_o(io_o), .io_oe(io_oe), .pat(pat),
    .io_i(io_i), .op_q(op_q), .ad_q(ad_q), .sr_q(sr_q), .n_q(n_q));
  // ==========================================
  // Compare and verdict
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic conclude();
    if (err_total == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : conclude
  // Expected read bytes and frame clocks
  function automatic int rdn(opcode_t op, int len);
    if (op inside {8'h05, 8'h35, 8'hab}) return 1;
    if (op == 8'h9f) return len > 3 ? 3 : len;
    return op inside {8'h03, 8'h0b, 8'h3b, 8'hbb, 8'h6b, 8'heb, 8'he7, 8'h48, 8'h90, 8'h92,
      8'h94} ? len : 0;
  endfunction : rdn
  function automatic int nclk(opcode_t op, int len);
    if (op inside {8'h06, 8'h04, 8'h50, 8'h60, 8'hc7, 8'hff, 8'h66, 8'h99, 8'hb9}) return 8;
    if (op inside {8'h20, 8'h52, 8'hd8}) return 32;
    if (op == 8'h01) return len > 2 ? 24 : 8 + 8 * len;
    if (op == 8'h31) return 16;
    return op == 8'h02 ? 32 + 8 * len : 0;
  endfunction : nclk
  // ==========================================
  // One command through the host
  task automatic run(input opcode_t op, input logic bad);
    int t, rn, len, k;
    logic er;
    len = $urandom_range(4, 1);
    cmd_op = op;
    cmd_addr = 24'($urandom);
    cmd_alt = 1'($urandom);
    cmd_len = 9'(len);
    pat = 8'($urandom);
    t = 0;
    // At least one edge between two requests
    do
    begin
      @(negedge clk);
      t++;
    end
    while (cmd_ready !== 1'b1 && t < 9000);
    chk("cmd_ready", cmd_ready, 1'b1);
    cmd_valid = 1'b1;
    @(negedge clk);
    cmd_valid = 1'b0;
    // Refusal pulse stands in the cycle right after the take
    er = (cmd_err === 1'b1);
    rn = 0;
    t = 0;
    while (done !== 1'b1 && !er && t < 5000)
    begin
      @(negedge clk);
      t++;
      er = (cmd_err === 1'b1);
      if (rd_valid === 1'b1)
      begin
        rn++;
        if (op inside {8'h03, 8'h0b, 8'h05, 8'h35, 8'h9f, 8'h90, 8'h48, 8'hab})
          chk("rd_data", rd_data, pat);
      end
    end
    chk("finish", (done === 1'b1) || er, 1'b1);
    chk("cmd_err", er, bad);
    if (!bad)
    begin
      k = nclk(op, len);
      chk("opcode", op_q, op);
      chk("reads", rn, rdn(op, len));
      if (k > 0) chk("clocks", n_q, k);
      if (op inside {8'h03, 8'h0b, 8'h3b, 8'h6b, 8'h48, 8'h90, 8'h20, 8'h52, 8'hd8, 8'h02})
        chk("address", ad_q, cmd_addr);
      if (op inside {8'h01, 8'h31, 8'h02})
        chk("wdata", sr_q[7:0], wb[(k - (op == 8'h02 ? 32 : 8)) / 8 - 1]);
    end
  endtask : run
  // ==========================================
  // Clock, watchdog and main sequence
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial
  begin
    #400000;
    err_total++;
    conclude();
  end
  initial
  begin
    void'($urandom(32'h8109db4e));
    {cmd_valid, cmd_op, cmd_addr, cmd_alt, cmd_len, wbuf_we, wbuf_addr, wbuf_data, pat} = '0;
    sys_rst = 1'b1;
    repeat (4) @(negedge clk);
    sys_rst = 1'b0;
    chk("cs_n", cs_n, 1'b1);
    chk("io_oe", io_oe, 4'hd);
    for (int i = 0; i < 4; i++)
    begin
      @(negedge clk);
      wb[i] = 8'($urandom);
      wbuf_we = 1'b1;
      wbuf_addr = 8'(i);
      wbuf_data = wb[i];
    end
    @(negedge clk);
    wbuf_we = 1'b0;
    foreach (ops[i]) run(ops[i], 1'b0);
    run(8'h38, 1'b1);
    run(8'h12, 1'b1);
    run(8'h66, 1'b0);
    run(8'h06, 1'b0);
    run(8'h99, 1'b1);
    run(8'h66, 1'b0);
    run(8'h99, 1'b0);
    run(8'hb9, 1'b0);
    chk("asleep", asleep, 1'b1);
    run(8'h05, 1'b1);
    run(8'hab, 1'b0);
    chk("asleep", asleep, 1'b0);
    conclude();
  end
endmodule : flash_host_test
